// >>> cnt_pkg.sv
package cnt_pkg;

	localparam int NUM_CHANNELS = 4;
	localparam int COUNT_WIDTH  = 32;
	localparam int DIG_LINES    = 8;
	localparam int ADDR_WIDTH   = 7;

	// Byte addresses inside a channel window, and of the global registers
	localparam logic [3:0] CFG_OFS      = 4'h0;
	localparam logic [3:0] START_OFS    = 4'h4;
	localparam logic [3:0] STOP_OFS     = 4'h8;
	localparam logic [3:0] COUNT_OFS    = 4'hc;
	localparam int         CH_SEL_LSB   = 4;
	localparam int         GLOBAL_BIT   = 6;
	localparam logic [6:0] CTRL_ADDR    = 7'h40;
	localparam logic [6:0] STATUS_ADDR  = 7'h44;

	// Control register fields
	localparam int         CTRL_SCAN_BIT = 0;

	// Status register fields
	localparam int         STATUS_DIG_LSB = 0;
	localparam int         STATUS_Z_LSB   = 8;

	// Reset values, and the write mask of the setting register
	localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
	localparam logic [31:0] START_RESET = 32'h0000_0000;
	localparam logic [31:0] STOP_RESET  = 32'h0000_ffff;
	localparam logic [31:0] CFG_WMASK   = 32'h777f_f31f;

	// Source and gate selector codes
	localparam logic [3:0] SEL_INT_CLK = 4'h0;
	localparam logic [3:0] SEL_TIMER1  = 4'h1;
	localparam logic [3:0] SEL_TIMER2  = 4'h2;
	localparam logic [3:0] GATE_NONE   = 4'h0;
	localparam logic [3:0] GATE_INT    = 4'h1;
	localparam logic [3:0] GATE_TIMER1 = 4'h2;
	localparam logic [3:0] GATE_TIMER2 = 4'h3;
	localparam int         SEL_DIG_BIT = 3;

	typedef enum logic [1:0] {
		single_count_per_cycle,
		double_count_per_cycle,
		quad_count_per_cycle,
		res_reserved
	} resolution_t;

	typedef struct packed {
		logic        rsv31;
		logic [2:0]  z_line;
		logic        rsv27;
		logic [2:0]  b_line;
		logic        rsv23;
		logic [2:0]  a_line;
		logic [3:0]  gate_sel;
		logic [3:0]  src_sel;
		logic [1:0]  rsv11;
		resolution_t resolution;
		logic [2:0]  rsv7;
		logic        falling;
		logic        down;
		logic        rollover;
		logic        clear_on_read;
		logic        encoder;
	} cfg_t;

	typedef struct packed {
		logic src;
		logic gate_ok;
		logic a;
		logic b;
	} chan_in_t;

endpackage

// >>> count_channel.sv
`timescale 1ns/10ps
module count_channel (
	input  wire logic                           clk,
	input  wire logic                           reset,
	input  wire logic                           ce,
	input  wire cnt_pkg::cfg_t                  cfg,
	input  wire logic [cnt_pkg::COUNT_WIDTH-1:0] start_val,
	input  wire logic [cnt_pkg::COUNT_WIDTH-1:0] stop_val,
	input  wire cnt_pkg::chan_in_t              ins,
	input  wire logic                           clear,
	output logic      [cnt_pkg::COUNT_WIDTH-1:0] count
);

	logic                           prev_src;
	logic                           prev_a;
	logic                           prev_b;
	logic                           next_prev_src;
	logic                           next_prev_a;
	logic                           next_prev_b;
	logic [cnt_pkg::COUNT_WIDTH-1:0] next_count;
	logic [cnt_pkg::COUNT_WIDTH-1:0] base;
	logic                           hit;
	logic                           a_rise;
	logic                           a_fall;
	logic                           b_rise;
	logic                           b_fall;
	logic                           up;
	logic                           dn;

	always_comb begin
		next_prev_src = ins.src;
		next_prev_a   = ins.a;
		next_prev_b   = ins.b;
		// A clear restarts from the start value; an event in the same cycle still counts
		base = clear ? start_val : count;
		hit = (cfg.falling ? (prev_src & ~ins.src) : (~prev_src & ins.src)) & ins.gate_ok;
		a_rise = ~prev_a & ins.a;
		a_fall = prev_a & ~ins.a;
		b_rise = ~prev_b & ins.b;
		b_fall = prev_b & ~ins.b;
		unique case (cfg.resolution)
			cnt_pkg::quad_count_per_cycle: begin
				up = (a_rise & ~ins.b) | (a_fall & ins.b) | (b_rise & ins.a) | (b_fall & ~ins.a);
				dn = (a_rise & ins.b) | (a_fall & ~ins.b) | (b_rise & ~ins.a) | (b_fall & ins.a);
			end
			cnt_pkg::double_count_per_cycle: begin
				up = (a_rise & ~ins.b) | (a_fall & ins.b);
				dn = (a_rise & ins.b) | (a_fall & ~ins.b);
			end
			cnt_pkg::single_count_per_cycle,
			cnt_pkg::res_reserved: begin
				up = a_rise & ~ins.b;
				dn = a_fall & ~ins.b;
			end
		endcase
		next_count = base;
		if (cfg.encoder) begin
			// In quad resolution both phases moving at once is a glitch, so neither direction is taken
			if (ins.gate_ok && up && !dn) begin
				next_count = base + 32'h0000_0001;
			end else if (ins.gate_ok && dn && !up) begin
				next_count = base - 32'h0000_0001;
			end
		end else if (hit) begin
			if (!cfg.down) begin
				if (base >= stop_val) begin
					next_count = cfg.rollover ? start_val : base;
				end else begin
					next_count = base + 32'h0000_0001;
				end
			end else begin
				if (base <= start_val) begin
					next_count = cfg.rollover ? stop_val : base;
				end else begin
					next_count = base - 32'h0000_0001;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count    <= 32'h0000_0000;
			prev_src <= 1'b0;
			prev_a   <= 1'b0;
			prev_b   <= 1'b0;
		end else if (ce) begin
			count    <= next_count;
			prev_src <= next_prev_src;
			prev_a   <= next_prev_a;
			prev_b   <= next_prev_b;
		end
	end

endmodule

// >>> counter_encoder_inputs.sv
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps

// Summary of operation
// - Four independent 32-bit channels, 20 MHz inputs
// - Each channel: event counter or quadrature encoder
// - Source: internal clock, timers, or line
// - Gate: none, internal clock, timers, line
// - Clear-on-read (event counter only) returns old value, restarts count
// - Default: cleared only by new scan
// - Totalize counts up, cleared by new scan
// - Programmable start value, default zero
// - Programmable stop value, default 65535, halts
// - Rollover wraps at a limit to other
// - Direction selectable: increment or decrement
// - Active edge selectable: rising or falling
// - Encoder resolution one, two, four per cycle
// - Encoder A, B, Z on selectable lines
// - Encoder count is signed, passes zero
module counter_encoder_inputs (
	input  wire logic                           clk,
	input  wire logic                           reset,
	input  wire logic                           ce,
	input  wire logic [cnt_pkg::DIG_LINES-1:0]  dig_in,
	input  wire logic                           int_clk,
	input  wire logic                           timer1,
	input  wire logic                           timer2,
	input  wire logic [cnt_pkg::ADDR_WIDTH-1:0] avs_address,
	input  wire logic                           avs_read,
	input  wire logic                           avs_write,
	input  wire logic [31:0]                    avs_writedata,
	input  wire logic [3:0]                     avs_byteenable,
	output logic      [31:0]                    avs_readdata,
	output logic                                avs_waitrequest
);

	localparam int NCH = cnt_pkg::NUM_CHANNELS;
	localparam int CW  = cnt_pkg::COUNT_WIDTH;
	localparam int DL  = cnt_pkg::DIG_LINES;

	// Digital line synchroniser
	logic [DL-1:0] dig_meta;
	logic [DL-1:0] dig_sync;
	logic [DL-1:0] next_dig_meta;
	logic [DL-1:0] next_dig_sync;

	// Register file
	cnt_pkg::cfg_t   cfg           [NCH];
	logic [CW-1:0]   start_val     [NCH];
	logic [CW-1:0]   stop_val      [NCH];
	cnt_pkg::cfg_t   next_cfg      [NCH];
	logic [CW-1:0]   next_start    [NCH];
	logic [CW-1:0]   next_stop     [NCH];
	logic [CW-1:0]   count         [NCH];
	cnt_pkg::chan_in_t ins         [NCH];
	logic [NCH-1:0]  chan_clear;
	logic [NCH-1:0]  z_level;

	// Bus handshake
	logic            next_waitrequest;
	logic [31:0]     next_readdata;
	logic            req;
	logic            capture;
	logic            commit;
	logic            is_chan;
	logic [1:0]      ch_sel;
	logic [3:0]      ch_ofs;
	logic            scan_start;
	logic [31:0]     rd_value;

	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old_v;
		for (int k = 0; k < 4; k++) begin
			if (be[k]) begin
				r[k*8 +: 8] = new_v[k*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic pick_source(
		input logic [3:0]    sel,
		input logic [DL-1:0] dig,
		input logic          ic,
		input logic          t1,
		input logic          t2
	);
		logic r;
		r = 1'b0;
		if (sel[cnt_pkg::SEL_DIG_BIT]) begin
			r = dig[sel[2:0]];
		end else if (sel == cnt_pkg::SEL_INT_CLK) begin
			r = ic;
		end else if (sel == cnt_pkg::SEL_TIMER1) begin
			r = t1;
		end else if (sel == cnt_pkg::SEL_TIMER2) begin
			r = t2;
		end
		return r;
	endfunction

	function automatic logic pick_gate(
		input logic [3:0]    sel,
		input logic [DL-1:0] dig,
		input logic          ic,
		input logic          t1,
		input logic          t2
	);
		logic r;
		// An unassigned code keeps the gate closed rather than counting freely
		r = 1'b0;
		if (sel[cnt_pkg::SEL_DIG_BIT]) begin
			r = dig[sel[2:0]];
		end else if (sel == cnt_pkg::GATE_NONE) begin
			r = 1'b1;
		end else if (sel == cnt_pkg::GATE_INT) begin
			r = ic;
		end else if (sel == cnt_pkg::GATE_TIMER1) begin
			r = t1;
		end else if (sel == cnt_pkg::GATE_TIMER2) begin
			r = t2;
		end
		return r;
	endfunction

	// Pins are asynchronous; internal timing sources share clk and are used directly
	always_comb begin
		next_dig_meta = dig_in;
		next_dig_sync = dig_meta;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dig_meta <= 8'h00;
			dig_sync <= 8'h00;
		end else if (ce) begin
			dig_meta <= next_dig_meta;
			dig_sync <= next_dig_sync;
		end
	end

	// Request decode
	always_comb begin
		req     = avs_read | avs_write;
		capture = req & avs_waitrequest;
		commit  = req & ~avs_waitrequest;
		is_chan = ~avs_address[cnt_pkg::GLOBAL_BIT];
		ch_sel  = avs_address[cnt_pkg::CH_SEL_LSB +: 2];
		ch_ofs  = avs_address[3:0];
		scan_start = commit & avs_write & (avs_address == cnt_pkg::CTRL_ADDR)
			& avs_byteenable[0] & avs_writedata[cnt_pkg::CTRL_SCAN_BIT];
	end

	// Read mux
	always_comb begin
		rd_value = 32'h0000_0000;
		if (is_chan) begin
			unique case (ch_ofs)
				cnt_pkg::CFG_OFS:   rd_value = cfg[ch_sel];
				cnt_pkg::START_OFS: rd_value = start_val[ch_sel];
				cnt_pkg::STOP_OFS:  rd_value = stop_val[ch_sel];
				cnt_pkg::COUNT_OFS: rd_value = count[ch_sel];
				default:            rd_value = 32'h0000_0000;
			endcase
		end else if (avs_address == cnt_pkg::STATUS_ADDR) begin
			rd_value[cnt_pkg::STATUS_DIG_LSB +: DL] = dig_sync;
			rd_value[cnt_pkg::STATUS_Z_LSB +: NCH]  = z_level;
		end
	end

	// One wait cycle: data is fetched on the first edge, presented on the second
	always_comb begin
		next_waitrequest = ~capture;
		next_readdata    = avs_readdata;
		if (capture && avs_read) begin
			next_readdata = rd_value;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (ce) begin
			avs_waitrequest <= next_waitrequest;
			avs_readdata    <= next_readdata;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : chan
			logic read_clear;

			always_comb begin
				next_cfg[g]   = cfg[g];
				next_start[g] = start_val[g];
				next_stop[g]  = stop_val[g];
				if (commit && avs_write && is_chan && ch_sel == 2'(g)) begin
					unique case (ch_ofs)
						cnt_pkg::CFG_OFS: begin
							next_cfg[g] = merge(cfg[g], avs_writedata, avs_byteenable)
								& cnt_pkg::CFG_WMASK;
						end
						cnt_pkg::START_OFS: begin
							next_start[g] = merge(start_val[g], avs_writedata, avs_byteenable);
						end
						cnt_pkg::STOP_OFS: begin
							next_stop[g] = merge(stop_val[g], avs_writedata, avs_byteenable);
						end
						default: begin
							next_cfg[g] = cfg[g];
						end
					endcase
				end
				// Cleared in the cycle the value is latched, so no event falls between
				read_clear = capture && avs_read && is_chan && ch_sel == 2'(g)
					&& ch_ofs == cnt_pkg::COUNT_OFS && cfg[g].clear_on_read && !cfg[g].encoder;
				chan_clear[g] = scan_start | read_clear;
				ins[g].src = pick_source(cfg[g].src_sel, dig_sync, int_clk, timer1, timer2);
				ins[g].gate_ok = pick_gate(cfg[g].gate_sel, dig_sync, int_clk, timer1, timer2);
				ins[g].a = dig_sync[cfg[g].a_line];
				ins[g].b = dig_sync[cfg[g].b_line];
				z_level[g] = dig_sync[cfg[g].z_line];
			end

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					cfg[g]       <= cnt_pkg::CFG_RESET;
					start_val[g] <= cnt_pkg::START_RESET;
					stop_val[g]  <= cnt_pkg::STOP_RESET;
				end else if (ce) begin
					cfg[g]       <= next_cfg[g];
					start_val[g] <= next_start[g];
					stop_val[g]  <= next_stop[g];
				end
			end

			// Every clk sample sees a 20 MHz input, since each level lasts several cycles
			count_channel u_count (
				.clk       (clk),
				.reset     (reset),
				.ce        (ce),
				.cfg       (cfg[g]),
				.start_val (start_val[g]),
				.stop_val  (stop_val[g]),
				.ins       (ins[g]),
				.clear     (chan_clear[g]),
				.count     (count[g])
			);
		end
	endgenerate

endmodule

// >>> cei_sva.sv
`timescale 1ns/10ps
module cei_checker (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        ce,
	input wire logic [7:0]  dig_in,
	input wire logic [6:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic rcap;
	// A read is taken only at an edge that sees waitrequest still high
	assign rcap = ce && avs_read && avs_waitrequest;

	a_ack_one_wait:
		assert property (ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("Request not answered after one wait cycle");
	a_wait_low_once:
		assert property (ce && !avs_waitrequest |=> avs_waitrequest)
		else $error("Waitrequest low for more than one cycle");
	a_idle_wait_high:
		assert property (ce && !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("Waitrequest dropped with no request");
	a_rdata_kept:
		assert property (!rcap |=> $stable(avs_readdata))
		else $error("Read data changed without a read");
	a_ctrl_reads_zero:
		assert property (rcap && avs_address == cnt_pkg::CTRL_ADDR |=> avs_readdata == 32'h0)
		else $error("Control register read not zero");
	a_hole_reads_zero:
		assert property (rcap && avs_address == 7'h48 |=> avs_readdata == 32'h0)
		else $error("Unmapped read not zero");
	a_cfg_rsv_zero:
		assert property (rcap && !avs_address[6] && avs_address[3:0] == cnt_pkg::CFG_OFS
			|=> (avs_readdata & ~cnt_pkg::CFG_WMASK) == 32'h0)
		else $error("Reserved setting bits read back set");
	a_status_lines:
		assert property (rcap && avs_address == cnt_pkg::STATUS_ADDR
			|=> avs_readdata[7:0] == $past(dig_in, 3))
		else $error("Status does not show synchronised lines");

	c_count_read: cover property (rcap && !avs_address[6] && avs_address[3:0] == 4'hc);
	c_scan: cover property (ce && avs_write && avs_waitrequest && avs_address == 7'h40);
	c_status: cover property (rcap && avs_address == cnt_pkg::STATUS_ADDR);
endmodule

bind counter_encoder_inputs cei_checker chk (.clk(clk), .reset(reset), .ce(ce),
	.dig_in(dig_in), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// >>> pulse_src.sv
`timescale 1ns/10ps
module pulse_src (
	input  wire logic       clk,
	output logic      [7:0] lines
);
	// Quadrature phases as {B, A}; A leads B when moving up
	logic [1:0] up_seq [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
	logic [1:0] dn_seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};

	// Pulled-down lines rest low
	initial lines = 8'h00;

	// Each level stands 35 ns, above the 25 ns minimum width
	task automatic step;
		repeat (6) @(posedge clk);
	endtask

	task automatic drive(input int l, input logic v);
		@(posedge clk);
		lines[l] <= v;
		step();
	endtask

	task automatic pulses(input int l, input int n);
		repeat (n) begin
			drive(l, 1'b1);
			drive(l, 1'b0);
		end
	endtask

	// Lines 0 and 1 carry A and B
	task automatic quad(input int n, input logic up);
		repeat (n) for (int p = 0; p < 4; p++) begin
			@(posedge clk);
			lines[1:0] <= up ? up_seq[p] : dn_seq[p];
			step();
		end
	endtask
endmodule

// >>> counter_encoder_inputs_tb.sv
`timescale 1ns/10ps
module counter_encoder_inputs_tb;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        ce = 1'b1;
	logic [2:0]  intsrc = 3'h0;
	logic [6:0]  avs_address = 7'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  lines;
	logic [31:0] rd;
	int          miscompares = 0;
	int          samples_checked = 0;

	always #2.5 clk = ~clk;

	pulse_src src (.clk(clk), .lines(lines));
	counter_encoder_inputs dut (.clk(clk), .reset(reset), .ce(ce), .dig_in(lines),
		.int_clk(intsrc[0]), .timer1(intsrc[1]), .timer2(intsrc[2]),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	task automatic finish_test;
		$display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Holds the request until an edge samples waitrequest low
	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			$display("[ERR] waitrequest expected 0 seen %b", avs_waitrequest);
			miscompares++;
			finish_test();
		end
	endtask

	task automatic chk(input string what, input logic [31:0] exp);
		samples_checked++;
		if (rd !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, rd);
			miscompares++;
		end
	endtask

	function automatic logic [6:0] ad(input int ch, input logic [3:0] ofs);
		return 7'(ch * 16) | {3'h0, ofs};
	endfunction

	task automatic rdc(input int ch, input logic [31:0] exp, input string what);
		bus(1'b0, ad(ch, cnt_pkg::COUNT_OFS), 32'h0);
		chk(what, exp);
	endtask

	task automatic scan;
		bus(1'b1, cnt_pkg::CTRL_ADDR, 32'h1);
	endtask

	task automatic t_defaults;
		bus(1'b0, ad(3, cnt_pkg::START_OFS), 32'h0);
		chk("start", 32'h0);
		bus(1'b0, ad(3, cnt_pkg::STOP_OFS), 32'h0);
		chk("stop", 32'h0000ffff);
		bus(1'b0, 7'h48, 32'h0);
		chk("hole", 32'h0);
		bus(1'b0, cnt_pkg::CTRL_ADDR, 32'h0);
		chk("ctrl", 32'h0);
		bus(1'b0, cnt_pkg::STATUS_ADDR, 32'h0);
		chk("status idle", 32'h0);
		bus(1'b1, ad(2, cnt_pkg::CFG_OFS), 32'hffffffff);
		bus(1'b0, ad(2, cnt_pkg::CFG_OFS), 32'h0);
		chk("cfg mask", cnt_pkg::CFG_WMASK);
		bus(1'b1, ad(2, cnt_pkg::CFG_OFS), 32'h0);
	endtask

	// Channel 0 counts line 2
	task automatic t_total_clear;
		bus(1'b1, ad(0, cnt_pkg::CFG_OFS), 32'h0000a000);
		scan();
		src.pulses(2, 5);
		rdc(0, 32'd5, "total");
		rdc(0, 32'd5, "total again");
		bus(1'b1, ad(0, cnt_pkg::CFG_OFS), 32'h0000a002);
		src.pulses(2, 3);
		rdc(0, 32'd8, "latched");
		rdc(0, 32'd0, "after clear");
	endtask

	task automatic t_limits;
		bus(1'b1, ad(0, cnt_pkg::START_OFS), 32'd2);
		bus(1'b1, ad(0, cnt_pkg::STOP_OFS), 32'd4);
		bus(1'b1, ad(0, cnt_pkg::CFG_OFS), 32'h0000a000);
		scan();
		rdc(0, 32'd2, "start load");
		src.pulses(2, 5);
		rdc(0, 32'd4, "stop hold");
		bus(1'b1, ad(0, cnt_pkg::CFG_OFS), 32'h0000a008);
		src.pulses(2, 1);
		rdc(0, 32'd3, "decrement");
		bus(1'b1, ad(0, cnt_pkg::CFG_OFS), 32'h0000a004);
		scan();
		src.pulses(2, 3);
		rdc(0, 32'd2, "wrap up");
		bus(1'b1, ad(0, cnt_pkg::CFG_OFS), 32'h0000a00c);
		scan();
		src.pulses(2, 1);
		rdc(0, 32'd4, "wrap down");
	endtask

	// Channel 3: falling edges of line 2, gated by line 3
	task automatic t_edge_gate;
		bus(1'b1, ad(3, cnt_pkg::CFG_OFS), 32'h000ba010);
		src.drive(3, 1'b1);
		scan();
		src.drive(2, 1'b1);
		rdc(3, 32'd0, "rise ignored");
		src.drive(2, 1'b0);
		rdc(3, 32'd1, "fall counted");
		src.drive(3, 1'b0);
		src.pulses(2, 2);
		rdc(3, 32'd1, "gate closed");
		src.drive(3, 1'b1);
		src.pulses(2, 2);
		rdc(3, 32'd3, "gate open");
		// Every channel still selects line 0 as its Z input
		src.drive(0, 1'b1);
		bus(1'b0, cnt_pkg::STATUS_ADDR, 32'h0);
		chk("status z", 32'h00000f09);
		src.drive(0, 1'b0);
	endtask

	// Pulses on line 2 while the clock enable is low are never seen by channel 3
	task automatic t_freeze;
		scan();
		@(posedge clk);
		ce <= 1'b0;
		src.pulses(2, 2);
		@(posedge clk);
		ce <= 1'b1;
		rdc(3, 32'd0, "frozen");
		src.pulses(2, 1);
		rdc(3, 32'd1, "resumed");
	endtask

	// Channel 1: A on line 0, B on line 1, every resolution
	task automatic t_encoder;
		logic [31:0] k;
		for (int r = 0; r < 3; r++) begin
			bus(1'b1, ad(1, cnt_pkg::CFG_OFS), 32'h01000001 | (32'(r) << 8));
			scan();
			k = 32'h1 << r;
			src.quad(2, 1'b0);
			rdc(1, 32'h0 - 2 * k, "below zero");
			src.quad(3, 1'b1);
			rdc(1, k, "resolution");
		end
	endtask

	// Channel 2 counts line 2 through a gate on timer 1
	task automatic t_gates;
		bus(1'b1, ad(2, cnt_pkg::CFG_OFS), 32'h0002a000);
		scan();
		src.pulses(2, 2);
		rdc(2, 32'd0, "timer gate low");
		intsrc[1] <= 1'b1;
		src.pulses(2, 2);
		intsrc[1] <= 1'b0;
		rdc(2, 32'd2, "timer gate high");
	endtask

	// Channel 2 from internal clock, timer 1, timer 2
	task automatic t_sources;
		for (int s = 0; s < 3; s++) begin
			bus(1'b1, ad(2, cnt_pkg::CFG_OFS), 32'(s) << 12);
			scan();
			repeat (2) begin
				intsrc[s] <= 1'b1;
				repeat (3) @(posedge clk);
				intsrc[s] <= 1'b0;
				repeat (3) @(posedge clk);
			end
			rdc(2, 32'd2, "source");
		end
	endtask

	// A second reset restores the default limits and empties the counts
	task automatic t_reset;
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		bus(1'b0, ad(0, cnt_pkg::STOP_OFS), 32'h0);
		chk("stop after reset", 32'h0000ffff);
		rdc(0, 32'd0, "count after reset");
	endtask

	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_defaults();
		t_total_clear();
		t_limits();
		t_edge_gate();
		t_freeze();
		t_encoder();
		t_gates();
		t_sources();
		t_reset();
		finish_test();
	end
endmodule
